// ==== hw/osc_cfg_ctrl.sv ====
// oscillator trim, low-power and crystal oscillator control with a wishbone register slave
//
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`include "osc_cfg.svh"
// Behaviour
// - seven-bit fine trim in bits 6:0, loaded from factory value picked by frequency fuse
// - read-only lock bit 7 in second trim register blocks changes to both trims
// - lock bit takes its reset value from the lock bit of the config fuse
// - four-bit temperature slope trim in bits 3:0, factory loaded by frequency fuse
// - low-power oscillator run-in-standby bit 1 keeps it running in every mode
// - low-power output only on request; gate opens four cycles after request with run-in-standby set, otherwise four plus LP_START_CYC cycles later
// - crystal source and start-up fields ignore writes while enabled or stable
// - start-up field bits 5:4 selects 1k, 16k, 32k or 64k crystal cycles
// - external clock source type skips the crystal start-up wait
// - source bit 2: zero means crystal, one means external clock on pin one
// - enabled with run-in-standby the crystal runs always, otherwise only on request
// - crystal output reaches peripherals only while at least one requests it
// - after start-up, standby-running crystal reaches requester within two to three cycles
// - run-in-standby keeps crystal on in active, idle and standby modes
// - crystal enable bit 0 overrides both pins and freezes source and start-up fields
// - crystal enable and run-in-standby writes need the io-protected write path
// - all four registers accept writes only under configuration change protection
// - stable flag is one only when the oscillator is requested and stable
module osc_cfg_ctrl
  import osc_pkg::*;
#(
  parameter logic [6:0] FINE_TRIM_F0  = 7'h40,  // factory fine trim, frequency fuse 0
  parameter logic [6:0] FINE_TRIM_F1  = 7'h40,  // factory fine trim, frequency fuse 1
  parameter logic [3:0] TEMP_TRIM_F0  = 4'h8,   // factory slope trim, frequency fuse 0
  parameter logic [3:0] TEMP_TRIM_F1  = 4'h8,   // factory slope trim, frequency fuse 1
  parameter int         LP_START_CYC  = 8,      // analog start-up of the low-power oscillator
  parameter int         XTAL_SU_1K    = `OSC_SU_1K,
  parameter int         XTAL_SU_16K   = `OSC_SU_16K,
  parameter int         XTAL_SU_32K   = `OSC_SU_32K,
  parameter int         XTAL_SU_64K   = `OSC_SU_64K
) (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        CFG_PROT_OPEN,
  input  wire logic        IO_PROT_OPEN,
  input  wire logic        FREQ_SELECT_FUSE,
  input  wire logic        TRIM_LOCK_FUSE_BIT,
  input  wire logic        LP_OSC_REQ,
  input  wire logic        LP_OSC_TICK,
  input  wire logic        XTAL_REQ,
  input  wire logic        XTAL_TICK,
  output logic      [6:0]  FINE_FREQ_TRIM,
  output logic      [3:0]  TEMP_SLOPE_TRIM,
  output logic             LP_OSC_RUN,
  output logic             LP_CLK_GATE,
  output logic             XTAL_RUN,
  output logic             XTAL_CLK_GATE,
  output logic             XTAL_PIN_OVERRIDE,
  output logic             XTAL_EXT_CLOCK
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic        ack_q;
  logic [31:0] rd_q;
  logic        fuse_loaded_q;
  logic [6:0]  fine_q;
  logic [3:0]  temp_q;
  logic        lock_q;
  logic        lp_rsb_q;
  logic        xt_en_q;
  logic        xt_rsb_q;
  logic        xt_sel_q;
  logic [1:0]  startup_count_sel_q;
  logic        lp_s1_q, lp_s2_q, lp_s3_q;
  logic        xt_s1_q, xt_s2_q, xt_s3_q;
  logic [7:0]  lp_cnt_q;
  logic        lp_gate_q;
  osc_xstate_t xt_state_q;
  logic [16:0] xt_cnt_q;
  logic [1:0]  xt_gcnt_q;
  logic        xt_gate_q;
  logic        wb_req;
  logic        wr_fire;
  logic [5:0]  idx;
  logic        lp_tick;
  logic        xt_tick;
  logic        lp_run;
  logic        xt_run;
  logic        xt_stable;
  logic        lp_stable;
  logic [16:0] su_len;
  logic [7:0]  lp_target;
  logic [7:0]  rd_d;
  // control register reset image; single bits are picked from it
  localparam logic [7:0] CTRL_RST = `OSC_CTRL_RST;

  // word hit on a register index
  function automatic logic osc_hit(input logic [5:0] a, input logic [5:0] reg_idx);
    osc_hit = (a == reg_idx);
  endfunction

  // start-up length for the programmed start-up field
  function automatic logic [16:0] osc_su_len(input logic [1:0] sel);
    unique case (sel)
      2'h0:    osc_su_len = 17'(XTAL_SU_1K);
      2'h1:    osc_su_len = 17'(XTAL_SU_16K);
      2'h2:    osc_su_len = 17'(XTAL_SU_32K);
      2'h3:    osc_su_len = 17'(XTAL_SU_64K);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  // one wait state: ack is registered and drops the cycle after it rose
  assign wb_req  = WB_CYC_I & WB_STB_I;
  assign idx     = WB_ADR_I[7:2];
  assign wr_fire = wb_req & WB_WE_I & ~ack_q & WB_SEL_I[0] & fuse_loaded_q;

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req & ~ack_q;
    end
  end

  // read mux; unmapped words read as zero and still ack
  always_comb begin
    rd_d = 8'h00;
    if (osc_hit(idx, `OSC_IDX_STATUS)) begin
      rd_d[`OSC_ST_XTAL_BIT] = xt_stable;
      rd_d[`OSC_ST_LP_BIT]   = lp_stable;
    end else if (osc_hit(idx, `OSC_IDX_FINE_TRIM)) begin
      rd_d[`OSC_FINE_MSB:0] = fine_q;
    end else if (osc_hit(idx, `OSC_IDX_TEMP_TRIM)) begin
      rd_d[`OSC_LOCK_BIT]   = lock_q;
      rd_d[`OSC_TEMP_MSB:0] = temp_q;
    end else if (osc_hit(idx, `OSC_IDX_LP_CTRL)) begin
      rd_d[`OSC_RSB_BIT] = lp_rsb_q;
    end else if (osc_hit(idx, `OSC_IDX_XTAL_CTRL)) begin
      rd_d[`OSC_STARTUP_COUNT_SEL_MSB:`OSC_STARTUP_COUNT_SEL_LSB] = startup_count_sel_q;
      rd_d[`OSC_XSEL_BIT] = xt_sel_q;
      rd_d[`OSC_RSB_BIT]  = xt_rsb_q;
      rd_d[`OSC_XEN_BIT]  = xt_en_q;
    end
  end

  // read data captured on the edge that raises ack
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      rd_q <= 32'h0000_0000;
    end else if (wb_req & ~ack_q & ~WB_WE_I) begin
      rd_q <= {24'h00_0000, rd_d};
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rd_q;

  // ----------------------------------------------------------------
  // fast oscillator trims
  // ----------------------------------------------------------------
  // fuses cannot be sampled under asynchronous reset, so they load on the first edge after release
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      fuse_loaded_q <= 1'b0;
      lock_q        <= 1'b0;
    end else if (!fuse_loaded_q) begin
      fuse_loaded_q <= 1'b1;
      lock_q        <= TRIM_LOCK_FUSE_BIT;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      fine_q <= 7'h00;
      temp_q <= 4'h0;
    end else if (!fuse_loaded_q) begin
      fine_q <= FREQ_SELECT_FUSE ? FINE_TRIM_F1 : FINE_TRIM_F0;
      temp_q <= FREQ_SELECT_FUSE ? TEMP_TRIM_F1 : TEMP_TRIM_F0;
    end else if (wr_fire && CFG_PROT_OPEN && !lock_q) begin
      if (osc_hit(idx, `OSC_IDX_FINE_TRIM)) begin
        fine_q <= WB_DAT_I[`OSC_FINE_MSB:0];
      end
      if (osc_hit(idx, `OSC_IDX_TEMP_TRIM)) begin
        temp_q <= WB_DAT_I[`OSC_TEMP_MSB:0];
      end
    end
  end

  assign FINE_FREQ_TRIM  = fine_q;
  assign TEMP_SLOPE_TRIM = temp_q;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      lp_rsb_q <= CTRL_RST[`OSC_RSB_BIT];
    end else if (wr_fire && CFG_PROT_OPEN && osc_hit(idx, `OSC_IDX_LP_CTRL)) begin
      lp_rsb_q <= WB_DAT_I[`OSC_RSB_BIT];
    end
  end

  // enable and run-in-standby need both protections
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      xt_en_q  <= 1'b0;
      xt_rsb_q <= 1'b0;
    end else if (wr_fire && CFG_PROT_OPEN && IO_PROT_OPEN && osc_hit(idx, `OSC_IDX_XTAL_CTRL)) begin
      xt_en_q  <= WB_DAT_I[`OSC_XEN_BIT];
      xt_rsb_q <= WB_DAT_I[`OSC_RSB_BIT];
    end
  end

  // source and start-up fields freeze while enabled or stable, using the value before this write
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      xt_sel_q <= 1'b0;
      startup_count_sel_q   <= 2'h0;
    end else if (wr_fire && CFG_PROT_OPEN && !xt_en_q && !xt_stable &&
                 osc_hit(idx, `OSC_IDX_XTAL_CTRL)) begin
      xt_sel_q <= WB_DAT_I[`OSC_XSEL_BIT];
      startup_count_sel_q   <= WB_DAT_I[`OSC_STARTUP_COUNT_SEL_MSB:`OSC_STARTUP_COUNT_SEL_LSB];
    end
  end

  assign XTAL_PIN_OVERRIDE = xt_en_q;
  assign XTAL_EXT_CLOCK    = xt_sel_q;

  // ----------------------------------------------------------------
  // oscillator tick synchronisers
  // ----------------------------------------------------------------
  // ticks are far slower than the system clock, so a rising edge after two flops counts a cycle
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      lp_s1_q <= 1'b0;
      lp_s2_q <= 1'b0;
      lp_s3_q <= 1'b0;
      xt_s1_q <= 1'b0;
      xt_s2_q <= 1'b0;
      xt_s3_q <= 1'b0;
    end else begin
      lp_s1_q <= LP_OSC_TICK;
      lp_s2_q <= lp_s1_q;
      lp_s3_q <= lp_s2_q;
      xt_s1_q <= XTAL_TICK;
      xt_s2_q <= xt_s1_q;
      xt_s3_q <= xt_s2_q;
    end
  end

  assign lp_tick = lp_s2_q & ~lp_s3_q;
  assign xt_tick = xt_s2_q & ~xt_s3_q;

  // ----------------------------------------------------------------
  // low-power oscillator
  // ----------------------------------------------------------------
  assign lp_run    = lp_rsb_q | LP_OSC_REQ;
  // analog start-up only counts when the oscillator was not already held on
  assign lp_target = lp_rsb_q ? 8'(`OSC_LP_GATE_CYC) : 8'(`OSC_LP_GATE_CYC + LP_START_CYC);

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      lp_cnt_q  <= 8'h00;
      lp_gate_q <= 1'b0;
    end else if (!LP_OSC_REQ) begin
      lp_cnt_q  <= 8'h00;
      lp_gate_q <= 1'b0;
    end else if (!lp_gate_q && lp_tick) begin
      lp_cnt_q  <= lp_cnt_q + 8'h01;
      lp_gate_q <= (lp_cnt_q + 8'h01) >= lp_target;
    end
  end

  assign lp_stable   = lp_gate_q;
  assign LP_OSC_RUN  = lp_run;
  assign LP_CLK_GATE = lp_gate_q;

  // ----------------------------------------------------------------
  // crystal oscillator sequencing
  // ----------------------------------------------------------------
  // held on in every non-power-down mode by run-in-standby; sleep state is outside this block
  assign xt_run = xt_en_q & (xt_rsb_q | XTAL_REQ);
  assign su_len = osc_su_len(startup_count_sel_q);

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      xt_state_q <= OSC_XS_OFF;
      xt_cnt_q   <= 17'h0_0000;
    end else begin
      unique case (xt_state_q)
        OSC_XS_OFF: begin
          xt_cnt_q <= 17'h0_0000;
          if (xt_run) begin
            xt_state_q <= xt_sel_q ? OSC_XS_READY : OSC_XS_START;
          end
        end
        OSC_XS_START: begin
          if (!xt_run) begin
            xt_state_q <= OSC_XS_OFF;
          end else if (xt_tick) begin
            xt_cnt_q <= xt_cnt_q + 17'h0_0001;
            if ((xt_cnt_q + 17'h0_0001) >= su_len) begin
              xt_state_q <= OSC_XS_READY;
            end
          end
        end
        OSC_XS_READY: begin
          if (!xt_run) begin
            xt_state_q <= OSC_XS_OFF;
          end
        end
        default: xt_state_q <= OSC_XS_OFF;
      endcase
    end
  end

  // output gate: two crystal cycles after a request once start-up is done
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      xt_gcnt_q <= 2'h0;
      xt_gate_q <= 1'b0;
    // closing on a lost run condition too keeps the flag from outliving the ready state by a cycle
    end else if (!XTAL_REQ || !xt_run || xt_state_q != OSC_XS_READY) begin
      xt_gcnt_q <= 2'h0;
      xt_gate_q <= 1'b0;
    end else if (!xt_gate_q && xt_tick) begin
      xt_gcnt_q <= xt_gcnt_q + 2'h1;
      xt_gate_q <= (xt_gcnt_q + 2'h1) >= 2'(`OSC_XTAL_GATE_CYC);
    end
  end

  assign xt_stable     = xt_gate_q;
  assign XTAL_RUN      = xt_run;
  assign XTAL_CLK_GATE = xt_gate_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking osc_cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  trim_lock_a: assert property (fuse_loaded_q && lock_q |=> $stable(fine_q) && $stable(temp_q))
    else $error("trim changed while locked");
  lock_fuse_a: assert property (!fuse_loaded_q |=> lock_q == $past(TRIM_LOCK_FUSE_BIT))
    else $error("lock not loaded from fuse");
  fine_fuse_a: assert property (!fuse_loaded_q |=>
    fine_q == ($past(FREQ_SELECT_FUSE) ? FINE_TRIM_F1 : FINE_TRIM_F0))
    else $error("fine trim not loaded from factory value");
  lp_gate_req_a: assert property (!LP_OSC_REQ |=> !lp_gate_q)
    else $error("low-power gate open without request");
  xt_field_freeze_a: assert property (xt_en_q || xt_stable |=> $stable(xt_sel_q) && $stable(startup_count_sel_q))
    else $error("source or start-up field changed while frozen");
  xt_ext_skip_a: assert property (xt_state_q == OSC_XS_OFF && xt_run && xt_sel_q |=>
    xt_state_q == OSC_XS_READY)
    else $error("external clock did not skip start-up");
  xt_off_a: assert property (!xt_en_q |=> xt_state_q == OSC_XS_OFF)
    else $error("crystal running while disabled");
  xt_gate_req_a: assert property (!XTAL_REQ |=> !xt_gate_q)
    else $error("crystal output without request");
  cfg_prot_a: assert property (wr_fire && !CFG_PROT_OPEN |=>
    $stable(lp_rsb_q) && $stable(xt_en_q) && $stable(xt_sel_q) && $stable(startup_count_sel_q))
    else $error("unprotected write took effect");
  io_prot_a: assert property (wr_fire && !IO_PROT_OPEN |=> $stable(xt_en_q) && $stable(xt_rsb_q))
    else $error("enable changed without io protection");
  xt_stable_req_a: assert property (xt_stable |-> $past(XTAL_REQ) && xt_state_q == OSC_XS_READY)
    else $error("stable flag without request");
  ack_pulse_a: assert property (ack_q |=> !ack_q)
    else $error("ack held longer than one cycle");

  xt_startup_c: cover property (xt_state_q == OSC_XS_START ##1 xt_state_q == OSC_XS_READY);
  xt_gate_c:    cover property ($rose(xt_gate_q));
  lp_gate_c:    cover property ($rose(lp_gate_q) && lp_rsb_q);
  locked_wr_c:  cover property (wr_fire && lock_q && osc_hit(idx, `OSC_IDX_FINE_TRIM));

endmodule

// ==== inc/osc_cfg.svh ====
// register map, field positions, reset values and timing counts of the oscillator block
`ifndef OSC_CFG_SVH
`define OSC_CFG_SVH
// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define OSC_IDX_STATUS     6'h03
`define OSC_IDX_FINE_TRIM  6'h11
`define OSC_IDX_TEMP_TRIM  6'h12
`define OSC_IDX_LP_CTRL    6'h18
`define OSC_IDX_XTAL_CTRL  6'h1c
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define OSC_FINE_MSB       6
`define OSC_TEMP_MSB       3
`define OSC_LOCK_BIT       7
`define OSC_RSB_BIT        1
`define OSC_XEN_BIT        0
`define OSC_XSEL_BIT       2
`define OSC_STARTUP_COUNT_SEL_LSB       4
`define OSC_STARTUP_COUNT_SEL_MSB       5
`define OSC_ST_XTAL_BIT    6
`define OSC_ST_LP_BIT      5
// ----------------------------------------------------------------
// reset values and timing counts (oscillator cycles)
// ----------------------------------------------------------------
`define OSC_CTRL_RST       8'h00
`define OSC_LP_GATE_CYC    4
`define OSC_XTAL_GATE_CYC  2
`define OSC_SU_1K          1024
`define OSC_SU_16K         16384
`define OSC_SU_32K         32768
`define OSC_SU_64K         65536
`endif

// ==== inc/osc_pkg.sv ====
// types shared by the oscillator configuration block
package osc_pkg;
  // crystal oscillator sequencing, one-hot
  typedef enum logic [2:0] {
    OSC_XS_OFF   = 3'b001,
    OSC_XS_START = 3'b010,
    OSC_XS_READY = 3'b100
  } osc_xstate_t;
endpackage

// ==== verif/tb_top.sv ====
// self-checking bench for the oscillator configuration block
`timescale 1ns/1ps
`include "osc_cfg.svh"
module tb_top;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  localparam logic [6:0] FT0 = 7'h15;
  localparam logic [6:0] FT1 = 7'h2a;
  localparam logic [3:0] TT0 = 4'h3;
  localparam logic [3:0] TT1 = 4'hc;
  logic        sys_clk, reset, wb_cyc, wb_stb, wb_we, wb_ack, cfg_open, io_open;
  logic        freq_fuse, lock_fuse, lp_req, lp_tick, x_req, x_tick;
  logic        lp_run, lp_gate, x_run, x_gate, x_pin, x_ext;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel;
  logic [31:0] wb_wdat, wb_rdat, q;
  logic [6:0]  fine;
  logic [3:0]  temp;
  logic [2:0]  tick_div;
  int          n_errors, num_checks, n;

  osc_cfg_ctrl #(
    .FINE_TRIM_F0(FT0), .FINE_TRIM_F1(FT1), .TEMP_TRIM_F0(TT0), .TEMP_TRIM_F1(TT1), .LP_START_CYC(8),
    .XTAL_SU_1K(4), .XTAL_SU_16K(8), .XTAL_SU_32K(12), .XTAL_SU_64K(16)
  ) dut_u (
    .SYS_CLK(sys_clk), .RESET(reset), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_WE_I(wb_we),
    .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_wdat), .WB_DAT_O(wb_rdat), .WB_ACK_O(wb_ack),
    .CFG_PROT_OPEN(cfg_open), .IO_PROT_OPEN(io_open), .FREQ_SELECT_FUSE(freq_fuse),
    .TRIM_LOCK_FUSE_BIT(lock_fuse), .LP_OSC_REQ(lp_req), .LP_OSC_TICK(lp_tick), .XTAL_REQ(x_req),
    .XTAL_TICK(x_tick), .FINE_FREQ_TRIM(fine), .TEMP_SLOPE_TRIM(temp), .LP_OSC_RUN(lp_run),
    .LP_CLK_GATE(lp_gate), .XTAL_RUN(x_run), .XTAL_CLK_GATE(x_gate), .XTAL_PIN_OVERRIDE(x_pin),
    .XTAL_EXT_CLOCK(x_ext)
  );

  // 40 ns system clock
  always #20 sys_clk = ~sys_clk;

  // both oscillator pins toggle every 4 clocks, so one oscillator cycle is 8 clocks
  always @(posedge sys_clk) begin
    tick_div <= tick_div + 3'h1;
    if (tick_div[1:0] == 2'h3) begin
      lp_tick <= ~lp_tick;
      x_tick  <= ~x_tick;
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle; entered and left just after a rising edge
  task automatic wb(input logic we, input logic [5:0] idx, input logic [7:0] d);
    int k;
    k = 0;
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= {idx, 2'b00};
    wb_sel  <= 4'h1;
    wb_wdat <= {24'h0, d};
    do begin
      @(posedge sys_clk);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    if (k >= 50) n_errors++;
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(q, {24'h0, exp});
  endtask

  // cycles until a gate reaches a level, bounded
  task automatic tgate(input logic xtal, input logic lvl);
    n = 0;
    while ((xtal ? x_gate : lp_gate) !== lvl && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  // window for e oscillator cycles, allowing for sync and phase slack
  function automatic logic [31:0] rng(input int e);
    return {31'h0, (n >= (e - 1) * 8) && (n <= e * 8 + 16)};
  endfunction

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk({25'h0, fine}, {25'h0, FT1});
    chk({28'h0, temp}, {28'h0, TT1});
    rd(`OSC_IDX_TEMP_TRIM, {4'h0, TT1});
    rd(`OSC_IDX_LP_CTRL, 8'h00);
    rd(`OSC_IDX_XTAL_CTRL, 8'h00);
    rd(`OSC_IDX_STATUS, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_prot;
    cfg_open <= 1'b0;
    wb(1'b1, `OSC_IDX_FINE_TRIM, 8'h33);
    rd(`OSC_IDX_FINE_TRIM, {1'b0, FT1});
    cfg_open <= 1'b1;
    wb(1'b1, `OSC_IDX_FINE_TRIM, 8'hff);
    rd(`OSC_IDX_FINE_TRIM, 8'h7f);
    chk({25'h0, fine}, 32'h7f);
    wb(1'b1, `OSC_IDX_TEMP_TRIM, 8'h8a);
    rd(`OSC_IDX_TEMP_TRIM, 8'h0a);
    chk({28'h0, temp}, 32'ha);
    wb(1'b1, 6'h05, 8'hff);
    rd(6'h05, 8'h00);
    $display("test protection done");
  endtask

  task automatic t_lp;
    lp_req <= 1'b1;
    @(posedge sys_clk);
    chk({31'h0, lp_run}, 32'h1);
    tgate(1'b0, 1'b1);
    chk(rng(12), 32'h1);
    rd(`OSC_IDX_STATUS, 8'h20);
    lp_req <= 1'b0;
    tgate(1'b0, 1'b0);
    chk({31'h0, n <= 3}, 32'h1);
    wb(1'b1, `OSC_IDX_LP_CTRL, 8'h02);
    chk({31'h0, lp_run}, 32'h1);
    rd(`OSC_IDX_STATUS, 8'h00);
    lp_req <= 1'b1;
    tgate(1'b0, 1'b1);
    chk(rng(4), 32'h1);
    lp_req <= 1'b0;
    tgate(1'b0, 1'b0);
    $display("test low-power oscillator done");
  endtask

  task automatic t_xtal;
    int su[4];
    su = '{4, 8, 12, 16};
    io_open <= 1'b0;
    wb(1'b1, `OSC_IDX_XTAL_CTRL, 8'h31);
    rd(`OSC_IDX_XTAL_CTRL, 8'h30);
    chk({31'h0, x_pin}, 32'h0);
    io_open <= 1'b1;
    wb(1'b1, `OSC_IDX_XTAL_CTRL, 8'h31);
    chk({31'h0, x_pin}, 32'h1);
    wb(1'b1, `OSC_IDX_XTAL_CTRL, 8'h05);
    rd(`OSC_IDX_XTAL_CTRL, 8'h31);
    chk({31'h0, x_run}, 32'h0);
    // every start-up code, disabling between runs as software must
    for (int k = 0; k < 4; k++) begin
      x_req <= 1'b0;
      wb(1'b1, `OSC_IDX_XTAL_CTRL, 8'h00);
      tgate(1'b1, 1'b0);
      wb(1'b1, `OSC_IDX_XTAL_CTRL, {2'b00, k[1:0], 4'h1});
      x_req <= 1'b1;
      tgate(1'b1, 1'b1);
      chk(rng(su[k] + 2), 32'h1);
    end
    rd(`OSC_IDX_STATUS, 8'h40);
    wb(1'b1, `OSC_IDX_XTAL_CTRL, 8'h00);
    rd(`OSC_IDX_XTAL_CTRL, 8'h30);
    x_req <= 1'b0;
    tgate(1'b1, 1'b0);
    chk({31'h0, n <= 3}, 32'h1);
    $display("test crystal start-up done");
  endtask

  task automatic t_ext;
    wb(1'b1, `OSC_IDX_XTAL_CTRL, 8'h35);
    rd(`OSC_IDX_XTAL_CTRL, 8'h35);
    chk({31'h0, x_ext}, 32'h1);
    x_req <= 1'b1;
    tgate(1'b1, 1'b1);
    chk(rng(2), 32'h1);
    x_req <= 1'b0;
    tgate(1'b1, 1'b0);
    chk({31'h0, x_gate}, 32'h0);
    wb(1'b1, `OSC_IDX_XTAL_CTRL, 8'h37);
    chk({31'h0, x_run}, 32'h1);
    repeat (40) @(posedge sys_clk);
    rd(`OSC_IDX_STATUS, 8'h00);
    x_req <= 1'b1;
    tgate(1'b1, 1'b1);
    chk(rng(2), 32'h1);
    x_req <= 1'b0;
    tgate(1'b1, 1'b0);
    $display("test external clock and standby done");
  endtask

  task automatic t_lock;
    reset     <= 1'b1;
    freq_fuse <= 1'b0;
    lock_fuse <= 1'b1;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({25'h0, fine}, {25'h0, FT0});
    chk({28'h0, temp}, {28'h0, TT0});
    rd(`OSC_IDX_TEMP_TRIM, {4'h8, TT0});
    wb(1'b1, `OSC_IDX_FINE_TRIM, 8'h01);
    rd(`OSC_IDX_FINE_TRIM, {1'b0, FT0});
    wb(1'b1, `OSC_IDX_TEMP_TRIM, 8'h01);
    rd(`OSC_IDX_TEMP_TRIM, {4'h8, TT0});
    $display("test trim lock done");
  endtask

  // ----------------------------------------------------------------
  // verdict, watchdog and main sequence
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // whole run needs well under 5000 cycles; a hang is cut at 30000
  initial begin
    repeat (30000) @(posedge sys_clk);
    n_errors++;
    report_and_stop();
  end

  initial begin
    {sys_clk, wb_cyc, wb_stb, wb_we, cfg_open, io_open, lock_fuse, lp_req, lp_tick, x_req, x_tick} = '0;
    reset = 1'b1;
    freq_fuse = 1'b1;
    wb_adr = 8'h00;
    wb_sel = 4'h0;
    wb_wdat = 32'h0;
    tick_div = 3'h0;
    n_errors = 0;
    num_checks = 0;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    t_reset();
    t_prot();
    t_lp();
    t_xtal();
    t_ext();
    t_lock();
    report_and_stop();
  end
endmodule
